/* File: dtp_pkg.sv */
// Package for the dual timer pair: register offsets, field positions, resets.
// Assumes a 16-bit register port with one-cycle-late read data.
package dtp_pkg;
	// ------------------------------------------------------------
	// Register offsets (word index on the register port)
	// ------------------------------------------------------------
	localparam logic [3:0] DTP_OFF_LO_CTRL  = 4'h0;
	localparam logic [3:0] DTP_OFF_HI_CTRL  = 4'h1;
	localparam logic [3:0] DTP_OFF_LO_PER   = 4'h2;
	localparam logic [3:0] DTP_OFF_HI_PER   = 4'h3;
	localparam logic [3:0] DTP_OFF_LO_CNT   = 4'h4;
	localparam logic [3:0] DTP_OFF_HI_CNT   = 4'h5;
	localparam logic [3:0] DTP_OFF_IRQ_STAT = 4'h6;
	localparam logic [3:0] DTP_OFF_IRQ_CLR  = 4'h7;
	localparam logic [3:0] DTP_OFF_IRQ_EN   = 4'h8;
	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int DTP_BIT_ON    = 15;
	localparam int DTP_BIT_IDLE  = 13;
	localparam int DTP_BIT_GATE  = 6;
	localparam int DTP_BIT_PS_HI = 5;
	localparam int DTP_BIT_PS_LO = 4;
	localparam int DTP_BIT_CHAIN = 3;
	localparam int DTP_BIT_CSRC  = 1;
	// Writable bits of each control register
	localparam logic [15:0] DTP_LO_CTRL_MASK = 16'hA07A;
	localparam logic [15:0] DTP_HI_CTRL_MASK = 16'hA072;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] DTP_CTRL_RST = 16'h0000;
	localparam logic [15:0] DTP_PER_RST  = 16'hFFFF;
	localparam logic [15:0] DTP_CNT_RST  = 16'h0000;
	// Prescaler terminal counts (divide minus one)
	localparam logic [7:0] DTP_PS_DIV1   = 8'h00;
	localparam logic [7:0] DTP_PS_DIV8   = 8'h07;
	localparam logic [7:0] DTP_PS_DIV64  = 8'h3F;
	localparam logic [7:0] DTP_PS_DIV256 = 8'hFF;
	// Interrupt status bits
	localparam int DTP_IRQ_LO = 0;
	localparam int DTP_IRQ_HI = 1;
endpackage : dtp_pkg

/* File: dtp_tick_if.sv */
// Interface carrying one timer's count-qualify signals into the tick unit.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface dtp_tick_if;
	logic       run;
	logic       ext_sel;
	logic       gate_en;
	logic [1:0] ps_sel;
	logic       ext_pin;
	logic       gate_pin;
	logic       tick;
	logic       restart;
	modport core (output run, output ext_sel, output gate_en, output ps_sel,
	              output ext_pin, output gate_pin, output restart, input tick);
	modport unit (input run, input ext_sel, input gate_en, input ps_sel,
	              input ext_pin, input gate_pin, input restart, output tick);
endinterface : dtp_tick_if

/* File: dtp_tick.sv */
// Tick unit: clock source choice, gating, prescaler for one 16-bit timer.
// Assumes pins are synchronous to core_clk.
`timescale 1ns/1ps
module dtp_tick
	import dtp_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	dtp_tick_if.unit  t
);
	logic       pin_q;
	logic [7:0] pre_q;
	logic [7:0] pre_d;
	logic [7:0] term;
	logic       rise;
	logic       raw;
	logic       hit;

	// Source selection; gate ignored for external source
	assign rise = t.ext_pin & ~pin_q;
	assign raw  = t.ext_sel ? rise                                 // see RULE13
	                        : (~t.gate_en | t.gate_pin);           // see RULE11, see RULE18
	assign term = (t.ps_sel == 2'b11) ? DTP_PS_DIV256 :
	              (t.ps_sel == 2'b10) ? DTP_PS_DIV64  :
	              (t.ps_sel == 2'b01) ? DTP_PS_DIV8   : DTP_PS_DIV1; // see RULE12
	assign hit  = t.run & raw & (pre_q >= term);
	assign pre_d = (~t.run | t.restart) ? 8'h00 :
	               hit ? 8'h00 :
	               raw ? pre_q + 8'h01 : pre_q;
	assign t.tick = hit;

	// Edge memory and prescale count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_q <= 1'b0;
			pre_q <= 8'h00;
		end else begin
			pin_q <= t.ext_pin;
			pre_q <= pre_d;
		end
	end
endmodule : dtp_tick

/* File: dtp_timer_pair.sv */
// Dual 16-bit timer pair, chainable to one 32-bit timer, with register port.
// Assumes a single core_clk domain; pins and idle flag synchronous to it.
`timescale 1ns/1ps
// Functional notes
// RULE1: Chain bit joins timers into 32 bits, lower word low, upper word high.
// RULE2: Chained, upper control ignored; lower control, clock and gate used.
// RULE3: Chained period match raises the upper timer's interrupt flag.
// RULE4: Chained period is upper period high word, lower period low word.
// RULE5: Chained count is upper count high word, lower count low word.
// RULE6: Unchained timers run independently, synchronous only.
// RULE7: Converter trigger comes only from the upper timer.
// RULE8: Chained mode interrupts when 32-bit count matches 32-bit period.
// RULE9: Bit 15 runs the timer; lower one runs the chained pair.
// RULE10: Bit 13 halts the timer in idle mode when set.
// RULE11: Bit 6 gates accumulation with internal clock, ignored with external.
// RULE12: Bits 5-4 prescale 1:1, 1:8, 1:64, 1:256.
// RULE13: Bit 1 selects external pin rising edge or internal clock.
// RULE14: Bit 3 of lower control selects chained or split mode.
// RULE15: Software configures chaining, periods, interrupt, then sets run bit.
// RULE16: Software configures split mode, period, interrupt, then sets run bit.
// RULE17: Count increments per tick, wraps to zero after period match, flags.
// RULE18: Gated mode counts internal clock only while gate is high.
module dtp_timer_pair
	import dtp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        idle_mode,
	input  wire logic        lower_ext_clock_pin,
	input  wire logic        upper_ext_clock_pin,
	input  wire logic        lower_gate_pin,
	input  wire logic        upper_gate_pin,
	output logic             irq,
	output logic             conv_trigger
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] lo_ctrl_q;
	logic [15:0] hi_ctrl_q;
	logic [15:0] lo_per_q;
	logic [15:0] hi_per_q;
	logic [15:0] lo_cnt_q;
	logic [15:0] lo_cnt_d;
	logic [15:0] hi_cnt_q;
	logic [15:0] hi_cnt_d;
	logic [1:0]  stat_q;
	logic [1:0]  stat_d;
	logic [1:0]  en_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        irq_q;
	logic        trig_q;

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	logic wr_lo_ctrl;
	logic wr_hi_ctrl;
	logic wr_lo_per;
	logic wr_hi_per;
	logic wr_lo_cnt;
	logic wr_hi_cnt;
	logic wr_clr;
	logic wr_en;

	assign wr_lo_ctrl = reg_wr & (reg_addr == DTP_OFF_LO_CTRL);
	assign wr_hi_ctrl = reg_wr & (reg_addr == DTP_OFF_HI_CTRL);
	assign wr_lo_per  = reg_wr & (reg_addr == DTP_OFF_LO_PER);
	assign wr_hi_per  = reg_wr & (reg_addr == DTP_OFF_HI_PER);
	assign wr_lo_cnt  = reg_wr & (reg_addr == DTP_OFF_LO_CNT);
	assign wr_hi_cnt  = reg_wr & (reg_addr == DTP_OFF_HI_CNT);
	assign wr_clr     = reg_wr & (reg_addr == DTP_OFF_IRQ_CLR);
	assign wr_en      = reg_wr & (reg_addr == DTP_OFF_IRQ_EN);

	// ------------------------------------------------------------
	// Mode and qualification
	// ------------------------------------------------------------
	logic chain;
	logic lo_run;
	logic hi_run;

	assign chain  = lo_ctrl_q[DTP_BIT_CHAIN];                       // see RULE14
	// Idle halts only when the stop-in-idle bit is set
	assign lo_run = lo_ctrl_q[DTP_BIT_ON] &
	                ~(idle_mode & lo_ctrl_q[DTP_BIT_IDLE]);         // see RULE9, see RULE10
	// Chained: upper runs from nothing of its own; its controls are dead
	assign hi_run = ~chain & hi_ctrl_q[DTP_BIT_ON] &
	                ~(idle_mode & hi_ctrl_q[DTP_BIT_IDLE]);         // see RULE2, see RULE6

	// ------------------------------------------------------------
	// Tick units, one per timer
	// ------------------------------------------------------------
	dtp_tick_if lo_if ();
	dtp_tick_if hi_if ();

	assign lo_if.run      = lo_run;
	assign lo_if.ext_sel  = lo_ctrl_q[DTP_BIT_CSRC];
	assign lo_if.gate_en  = lo_ctrl_q[DTP_BIT_GATE];
	assign lo_if.ps_sel   = lo_ctrl_q[DTP_BIT_PS_HI:DTP_BIT_PS_LO];
	assign lo_if.ext_pin  = lower_ext_clock_pin;
	assign lo_if.gate_pin = lower_gate_pin;
	assign lo_if.restart  = wr_lo_ctrl;
	assign hi_if.run      = hi_run;
	assign hi_if.ext_sel  = hi_ctrl_q[DTP_BIT_CSRC];
	assign hi_if.gate_en  = hi_ctrl_q[DTP_BIT_GATE];
	assign hi_if.ps_sel   = hi_ctrl_q[DTP_BIT_PS_HI:DTP_BIT_PS_LO];
	assign hi_if.ext_pin  = upper_ext_clock_pin;
	assign hi_if.gate_pin = upper_gate_pin;
	assign hi_if.restart  = wr_hi_ctrl;

	dtp_tick u_lo_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.t        (lo_if.unit)
	);

	dtp_tick u_hi_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.t        (hi_if.unit)
	);

	// ------------------------------------------------------------
	// Count and match
	// ------------------------------------------------------------
	logic [31:0] cnt32;
	logic [31:0] per32;
	logic        match32;
	logic        lo_match;
	logic        hi_match;
	logic        lo_ev;
	logic        hi_ev;
	logic        ev32;

	assign cnt32    = {hi_cnt_q, lo_cnt_q};                         // see RULE1, see RULE5
	assign per32    = {hi_per_q, lo_per_q};                         // see RULE4
	assign match32  = (cnt32 == per32);                             // see RULE8
	assign lo_match = (lo_cnt_q == lo_per_q);
	assign hi_match = (hi_cnt_q == hi_per_q);
	// Events fire on the tick that wraps the count after a match
	assign ev32  = chain & lo_if.tick & match32;                    // see RULE8
	assign lo_ev = ~chain & lo_if.tick & lo_match;                  // see RULE17
	assign hi_ev = ~chain & hi_if.tick & hi_match;                  // see RULE17

	// Next count; a software write takes priority over counting
	always_comb begin
		lo_cnt_d = lo_cnt_q;
		hi_cnt_d = hi_cnt_q;
		if (chain) begin
			if (lo_if.tick) begin
				{hi_cnt_d, lo_cnt_d} = match32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001; // see RULE1
			end
		end else begin
			if (lo_if.tick) begin
				lo_cnt_d = lo_match ? DTP_CNT_RST : lo_cnt_q + 16'h0001; // see RULE17
			end
			if (hi_if.tick) begin
				hi_cnt_d = hi_match ? DTP_CNT_RST : hi_cnt_q + 16'h0001; // see RULE17
			end
		end
		if (wr_lo_cnt) begin
			lo_cnt_d = reg_wdata;
		end
		if (wr_hi_cnt) begin
			hi_cnt_d = reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status: set wins over a same-cycle clear
	// ------------------------------------------------------------
	logic [1:0] set_v;
	logic [1:0] clr_v;

	assign set_v[DTP_IRQ_LO] = lo_ev;                               // see RULE3
	assign set_v[DTP_IRQ_HI] = hi_ev | ev32;                        // see RULE3
	assign clr_v  = wr_clr ? reg_wdata[1:0] : 2'b00;
	assign stat_d = (stat_q & ~clr_v) | set_v;

	// ------------------------------------------------------------
	// Read mux, data one cycle after the strobe
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				DTP_OFF_LO_CTRL:  rdata_d = lo_ctrl_q;
				DTP_OFF_HI_CTRL:  rdata_d = hi_ctrl_q;
				DTP_OFF_LO_PER:   rdata_d = lo_per_q;
				DTP_OFF_HI_PER:   rdata_d = hi_per_q;
				DTP_OFF_LO_CNT:   rdata_d = lo_cnt_q;
				DTP_OFF_HI_CNT:   rdata_d = hi_cnt_q;
				DTP_OFF_IRQ_STAT: rdata_d = {14'h0000, stat_q};
				DTP_OFF_IRQ_EN:   rdata_d = {14'h0000, en_q};
				default:          rdata_d = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------
	// Control and period storage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lo_ctrl_q <= DTP_CTRL_RST;
			hi_ctrl_q <= DTP_CTRL_RST;
			lo_per_q  <= DTP_PER_RST;
			hi_per_q  <= DTP_PER_RST;
			en_q      <= 2'b00;
		end else begin
			if (wr_lo_ctrl) lo_ctrl_q <= reg_wdata & DTP_LO_CTRL_MASK;
			if (wr_hi_ctrl) hi_ctrl_q <= reg_wdata & DTP_HI_CTRL_MASK;
			if (wr_lo_per)  lo_per_q  <= reg_wdata;
			if (wr_hi_per)  hi_per_q  <= reg_wdata;
			if (wr_en)      en_q      <= reg_wdata[1:0];
		end
	end

	// Counts, status and registered outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lo_cnt_q  <= DTP_CNT_RST;
			hi_cnt_q  <= DTP_CNT_RST;
			stat_q    <= 2'b00;
			rdata_q   <= 16'h0000;
			irq_q     <= 1'b0;
			trig_q    <= 1'b0;
		end else begin
			lo_cnt_q  <= lo_cnt_d;
			hi_cnt_q  <= hi_cnt_d;
			stat_q    <= stat_d;
			rdata_q   <= rdata_d;
			irq_q     <= |(stat_d & en_q);
			trig_q    <= hi_ev | ev32;                              // see RULE7
		end
	end

	assign reg_rdata    = rdata_q;
	assign irq          = irq_q;
	assign conv_trigger = trig_q;
endmodule : dtp_timer_pair

/* File: dtp_pins_model.sv */
// Model of the pins beside the timer pair: external count clocks and gates.
// Assumes pins are driven synchronously to core_clk, just after its rising edge.
`timescale 1ns/1ps
module dtp_pins_model (
	input  wire logic core_clk,
	output logic      lo_clk,
	output logic      hi_clk,
	output logic      lo_gate,
	output logic      hi_gate
);
	// Count clocks stand low outside bursts; no free-running source here
	initial begin
		{lo_clk, hi_clk, lo_gate, hi_gate} = 4'h0;
	end
	// Burst of n rising edges on both clock pins, four cycles each
	task automatic edges(input int n);
		repeat (n) begin
			@(posedge core_clk);
			{lo_clk, hi_clk} <= 2'h3;
			repeat (2) @(posedge core_clk);
			{lo_clk, hi_clk} <= 2'h0;
			@(posedge core_clk);
		end
	endtask : edges
	// Hold both gates high for n cycles
	task automatic gate(input int n);
		@(posedge core_clk);
		{lo_gate, hi_gate} <= 2'h3;
		repeat (n) @(posedge core_clk);
		{lo_gate, hi_gate} <= 2'h0;
	endtask : gate
endmodule : dtp_pins_model

/* File: dtp_timer_pair_props.sv */
// Checker for the timer pair, seeing only top-level ports.
// Assumes the register map and control masks of dtp_pkg.
`timescale 1ns/1ps
module dtp_timer_pair_props
	import dtp_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        irq,
	input wire logic        conv_trigger
);
	logic [1:0] en_q;
	logic [1:0] run_q;
	// Shadow of enables and run bits, so masking can be judged from ports
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_q  <= 2'h0;
			run_q <= 2'h0;
		end else if (reg_wr && reg_addr == DTP_OFF_IRQ_EN) begin
			en_q <= reg_wdata[1:0];
		end else if (reg_wr && reg_addr <= DTP_OFF_HI_CTRL) begin
			run_q[reg_addr[0]] <= reg_wdata[DTP_BIT_ON];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (reg_rd && reg_addr > DTP_OFF_IRQ_EN |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_clear_reads_zero: assert property (reg_rd && reg_addr == DTP_OFF_IRQ_CLR |=> !reg_rdata)
		else $error("clear register read not zero");
	a_lo_ctrl_bits: assert property (reg_rd && reg_addr == DTP_OFF_LO_CTRL
		|=> (reg_rdata & ~DTP_LO_CTRL_MASK) == 16'h0000) else $error("lower control stray bits");
	a_hi_no_chain: assert property (reg_rd && reg_addr == DTP_OFF_HI_CTRL
		|=> (reg_rdata & ~DTP_HI_CTRL_MASK) == 16'h0000) else $error("upper control stray bits");
	a_status_two_bits: assert property (reg_rd && reg_addr == DTP_OFF_IRQ_STAT
		|=> reg_rdata[15:2] == 14'h0000) else $error("status stray bits");
	a_irq_masked: assert property ((en_q == 2'h0) [*2] |-> !irq)
		else $error("interrupt high while all enables clear");
	a_trig_stopped: assert property ((run_q == 2'h0) [*3] |-> !conv_trigger)
		else $error("trigger while both timers stopped");
	a_trig_sets_irq: assert property (conv_trigger && en_q[DTP_IRQ_HI]
		&& !(reg_wr && reg_addr == DTP_OFF_IRQ_EN)
		&& !(reg_wr && reg_addr == DTP_OFF_IRQ_CLR) |=> irq) else $error("wrap did not raise irq");
endmodule : dtp_timer_pair_props
bind dtp_timer_pair dtp_timer_pair_props u_props (.core_clk(core_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq(irq), .conv_trigger(conv_trigger));

/* File: dtp_timer_pair_tb_top.sv */
// Testbench for the timer pair: register tasks, pin model, self-checks.
// Assumes the pin model drives the external clocks and gates.
`timescale 1ns/1ps
module dtp_timer_pair_tb_top;
	import dtp_pkg::*;
	logic        core_clk, rst, reg_wr, reg_rd, idle_mode, irq, conv_trigger;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, a_v, b_v, c_v;
	logic        lo_ck, hi_ck, lo_g, hi_g;
	int          n_mismatch = 0, checks = 0, cyc = 0, trig_n = 0;
	logic [15:0] rv [10] = '{16'h0, 16'h0, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h0, 16'h0};
	int          nn [4] = '{20, 36, 288, 1152};
	logic [15:0] plo [4] = '{16'h0013, 16'h0004, 16'h0004, 16'h0004};
	logic [15:0] phi [4] = '{16'h0018, 16'h0004, 16'h0004, 16'h0004};
	dtp_timer_pair DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.idle_mode(idle_mode), .lower_ext_clock_pin(lo_ck), .upper_ext_clock_pin(hi_ck),
		.lower_gate_pin(lo_g), .upper_gate_pin(hi_g), .irq(irq), .conv_trigger(conv_trigger));
	dtp_pins_model pins (.core_clk(core_clk), .lo_clk(lo_ck), .hi_clk(hi_ck), .lo_gate(lo_g),
		.hi_gate(hi_g));
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	// Trigger pulse counter and hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (conv_trigger === 1'b1) trig_n++;
		if (cyc == 6000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Answer stands one cycle after the strobe; sampled mid-cycle
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
	// Range compare; lo equal to hi makes it exact
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] lo, hi);
		checks++;
		if (((got >= lo) && (got <= hi)) !== 1'b1) begin
			n_mismatch++;
			$display("unexpected %s: expected %h..%h seen %h", nm, lo, hi, got);
		end
	endtask : chk
	task automatic rc(input string nm, input logic [3:0] a, input logic [15:0] lo, hi);
		logic [15:0] v;
		rd(a, v);
		chk(nm, v, lo, hi);
	endtask : rc
	task automatic irq_is(input logic e);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		chk("irq", {15'h0, irq}, {15'h0, e}, {15'h0, e});
	endtask : irq_is
	initial begin
		{reg_wr, reg_rd, idle_mode, reg_addr, reg_wdata} = '0;
		rst = 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		wr(DTP_OFF_IRQ_STAT, 16'hFFFF);
		wr(4'h9, 16'hFFFF);
		for (int i = 0; i < 10; i++) rc("reset value", 4'(i), rv[i], rv[i]);
		wr(DTP_OFF_LO_CTRL, 16'hFFFF);
		rc("lower control", DTP_OFF_LO_CTRL, 16'hA07A, 16'hA07A);
		wr(DTP_OFF_HI_CTRL, 16'hFFFF);
		rc("upper control", DTP_OFF_HI_CTRL, 16'hA072, 16'hA072);
		wr(DTP_OFF_HI_CTRL, 16'h0030);
		$display("registers done");
		for (int p = 0; p < 4; p++) begin
			wr(DTP_OFF_LO_CTRL, 16'h0000);
			wr(DTP_OFF_LO_CNT, 16'h0000);
			wr(DTP_OFF_LO_CTRL, 16'(16'h8000 | (p << 4)));
			repeat (nn[p]) @(posedge core_clk);
			wr(DTP_OFF_LO_CTRL, 16'h0000);
			rc("prescaled count", DTP_OFF_LO_CNT, plo[p], phi[p]);
		end
		$display("prescale done");
		wr(DTP_OFF_LO_CNT, 16'hFFFE);
		wr(DTP_OFF_HI_CNT, 16'h1234);
		wr(DTP_OFF_LO_CTRL, 16'h8008);
		repeat (10) @(posedge core_clk);
		wr(DTP_OFF_LO_CTRL, 16'h0008);
		rc("carry high", DTP_OFF_HI_CNT, 16'h1235, 16'h1235);
		rc("carry low", DTP_OFF_LO_CNT, 16'h0008, 16'h000D);
		// Setup order: chain, mode, periods, interrupt, then run
		wr(DTP_OFF_LO_PER, 16'h0003);
		wr(DTP_OFF_HI_PER, 16'h0001);
		wr(DTP_OFF_LO_CNT, 16'hFFFE);
		wr(DTP_OFF_HI_CNT, 16'h0000);
		wr(DTP_OFF_IRQ_EN, 16'h0002);
		trig_n = 0;
		wr(DTP_OFF_LO_CTRL, 16'h8008);
		repeat (20) @(posedge core_clk);
		wr(DTP_OFF_LO_CTRL, 16'h0008);
		rc("chained status", DTP_OFF_IRQ_STAT, 16'h0002, 16'h0002);
		rc("wrapped high", DTP_OFF_HI_CNT, 16'h0000, 16'h0000);
		chk("chained trig", 16'(trig_n), 16'h0001, 16'h0001);
		irq_is(1'b1);
		wr(DTP_OFF_IRQ_CLR, 16'h0002);
		irq_is(1'b0);
		$display("chained done");
		wr(DTP_OFF_LO_CTRL, 16'h0000);
		wr(DTP_OFF_LO_PER, 16'h0002);
		wr(DTP_OFF_LO_CNT, 16'h0000);
		wr(DTP_OFF_IRQ_EN, 16'h0000);
		trig_n = 0;
		wr(DTP_OFF_LO_CTRL, 16'h8000);
		repeat (20) @(posedge core_clk);
		rc("split status", DTP_OFF_IRQ_STAT, 16'h0001, 16'h0001);
		rc("split low", DTP_OFF_LO_CNT, 16'h0000, 16'h0002);
		chk("lower trig", 16'(trig_n), 16'h0000, 16'h0000);
		irq_is(1'b0);
		wr(DTP_OFF_IRQ_EN, 16'h0001);
		irq_is(1'b1);
		wr(DTP_OFF_HI_PER, 16'h0002);
		wr(DTP_OFF_HI_CNT, 16'h0000);
		wr(DTP_OFF_HI_CTRL, 16'h8000);
		repeat (20) @(posedge core_clk);
		wr(DTP_OFF_HI_CTRL, 16'h0000);
		chk("upper trig", 16'(trig_n), 16'h0005, 16'h0009);
		wr(DTP_OFF_LO_CTRL, 16'h0000);
		wr(DTP_OFF_IRQ_CLR, 16'h0003);
		irq_is(1'b0);
		$display("split done");
		wr(DTP_OFF_LO_PER, 16'hFFFF);
		wr(DTP_OFF_LO_CNT, 16'h0000);
		wr(DTP_OFF_LO_CTRL, 16'h8042);
		// Upper timer on its own pin too, so its source select is exercised
		wr(DTP_OFF_HI_PER, 16'hFFFF);
		wr(DTP_OFF_HI_CNT, 16'h0000);
		wr(DTP_OFF_HI_CTRL, 16'h8042);
		pins.edges(5);
		rc("external count", DTP_OFF_LO_CNT, 16'h0005, 16'h0005);
		rc("upper external", DTP_OFF_HI_CNT, 16'h0005, 16'h0005);
		wr(DTP_OFF_HI_CTRL, 16'h0000);
		wr(DTP_OFF_LO_CTRL, 16'h0000);
		wr(DTP_OFF_LO_CNT, 16'h0000);
		wr(DTP_OFF_LO_CTRL, 16'h8040);
		repeat (10) @(posedge core_clk);
		pins.gate(12);
		repeat (5) @(posedge core_clk);
		rc("gated count", DTP_OFF_LO_CNT, 16'h000A, 16'h000D);
		wr(DTP_OFF_LO_CTRL, 16'hA000);
		idle_mode <= 1'b1;
		rd(DTP_OFF_LO_CNT, a_v);
		repeat (10) @(posedge core_clk);
		rd(DTP_OFF_LO_CNT, b_v);
		chk("idle halt", b_v, a_v, a_v);
		wr(DTP_OFF_LO_CTRL, 16'h8000);
		repeat (10) @(posedge core_clk);
		rd(DTP_OFF_LO_CNT, c_v);
		chk("idle run", c_v, b_v + 16'h8, b_v + 16'h14);
		idle_mode <= 1'b0;
		$display("pins and idle done");
		give_verdict();
	end
endmodule : dtp_timer_pair_tb_top
